// ===== hw/pgl_pkg.sv
// Constants shared by the paging register and logic fabric
package pgl_pkg;
  // ==========================================================
  // Register map inside the register-block select space
  localparam logic [7:0] OFS_PAGE      = 8'he0;
  localparam logic [7:0] OFS_CELLS_A   = 8'h20;
  localparam logic [7:0] OFS_CELLS_B   = 8'h21;
  localparam logic [7:0] OFS_INCELL_A  = 8'h10;
  localparam logic [7:0] OFS_INCELL_B  = 8'h11;
  localparam logic [7:0] OFS_INCELL_C  = 8'h12;
  localparam logic [7:0] PAGE_RESET    = 8'h00;
  localparam logic [7:0] RDATA_UNMAP   = 8'h00;

  // ==========================================================
  // Array input vector layout
  localparam int IN_W      = 69;
  localparam int IX_ADDR   = 0;
  localparam int IX_STB    = 16;
  localparam int IX_RST    = 20;
  localparam int IX_PDN    = 21;
  localparam int IX_ICELL  = 22;
  localparam int IX_PORTD  = 42;
  localparam int IX_PAGE   = 44;
  localparam int IX_FB     = 52;
  localparam int IX_READY  = 68;
  localparam int N_ICELL   = 20;
  localparam int N_CELL    = 16;
  localparam int N_STB_BLK = 5;

  // ==========================================================
  // Decode array term layout
  localparam int DEC_PT    = 23;
  localparam int DX_PRI    = 0;
  localparam int DX_SEC    = 12;
  localparam int DX_SRAM   = 18;
  localparam int DX_RBS    = 20;
  localparam int DX_PERI   = 21;
  localparam int PRI_TERMS = 3;
  localparam int SEC_TERMS = 3;

  // ==========================================================
  // General array term layout (array limit is 137 terms)
  localparam int GEN_PT_MAX = 137;
  localparam int CELL_PT    = 8;
  localparam int GX_ECS     = 128;
  localparam int ECS_TERMS  = 3;
  localparam int GEN_PT     = 134;
  localparam int CELL_CFG_W = 5;

  // ==========================================================
  // Output cell flip-flop kinds
  localparam logic [1:0] FF_D  = 2'h0;
  localparam logic [1:0] FF_T  = 2'h1;
  localparam logic [1:0] FF_JK = 2'h2;
  localparam logic [1:0] FF_SR = 2'h3;

  // ==========================================================
  // Standby timing
  localparam int CLK_MHZ     = 50;
  localparam int STBY_NS     = 70;
  localparam int STBY_CYC    = (STBY_NS * CLK_MHZ + 999) / 1000;
  localparam int STBY_CNT_W  = 3;
endpackage

// ===== hw/pgl_out_cell.sv
// One output cell of the general logic array
`timescale 1ns/1ns
module pgl_out_cell (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // Product terms from the array
  input  wire logic [3:0] sum_terms,
  input  wire logic       preset_term,
  input  wire logic [1:0] clear_terms,
  input  wire logic       clk_term,
  // Static cell configuration
  input  wire logic       polarity,
  input  wire logic [1:0] ff_kind,
  input  wire logic       registered,
  input  wire logic       use_pin_clk,
  // Clock pin rising-edge pulse
  input  wire logic       pin_rise,
  // Processor load path
  input  wire logic       load,
  input  wire logic       load_bit,
  // Cell results
  output logic            cell_out,
  output logic            cell_q
);
  logic sum_a;
  logic sum_b;
  logic comb_val;
  logic clk_term_q;
  logic tick;
  logic next_q;

  // Polarity XOR after the OR of the native terms
  assign sum_a    = polarity ^ (sum_terms[0] | sum_terms[1]);
  assign sum_b    = polarity ^ (sum_terms[2] | sum_terms[3]);
  assign comb_val = polarity ^ (|sum_terms);

  // Term clock becomes a rising-edge tick; pin clock comes pre-edged
  assign tick = use_pin_clk ? pin_rise : (clk_term & ~clk_term_q);

  always_ff @(posedge core_clk)
  begin
    if (rst)
      clk_term_q <= 1'b0;
    else
      clk_term_q <= clk_term;
  end

  // Flip-flop kind selects the next state
  always_comb
  begin
    case (ff_kind)
      pgl_pkg::FF_T:  next_q = cell_q ^ comb_val;
      pgl_pkg::FF_JK: next_q = (sum_a & ~cell_q) | (~sum_b & cell_q);
      pgl_pkg::FF_SR: next_q = sum_a | (~sum_b & cell_q);
      default: next_q = comb_val;
    endcase
  end

  // Processor load beats preset/clear, which beat the clock
  always_ff @(posedge core_clk)
  begin
    if (rst)
      cell_q <= 1'b0;
    else if (load)
      cell_q <= load_bit;
    else if (preset_term)
      cell_q <= 1'b1;
    else if (|clear_terms)
      cell_q <= 1'b0;
    else if (tick)
      cell_q <= next_q;
  end

  // Registered or combinational result drives pin and feedback
  assign cell_out = registered ? cell_q : comb_val;
endmodule

// ===== hw/pgl_fabric.sv
// Paging register, decode array and general logic array
`timescale 1ns/1ns
module pgl_fabric (
  // Clock and reset
  input  wire logic                          core_clk,
  input  wire logic                          rst,
  // Processor bus
  input  wire logic [15:0]                   addr,
  input  wire logic                          program_fetch_strobe_n,
  input  wire logic                          rd_n,
  input  wire logic                          wr_n,
  input  wire logic                          ale,
  input  wire logic [7:0]                    data_in,
  output logic [7:0]                         data_out,
  output logic                               data_out_en,
  // Module status inputs
  input  wire logic                          flash_ready,
  input  wire logic                          periph_io_mode,
  input  wire logic                          fast_mode,
  input  wire logic [4:0]                    strobe_block,
  // Pins
  input  wire logic                          power_down_input,
  input  wire logic [19:0]                   input_cell_pins,
  input  wire logic                          cell_clock_pin,
  input  wire logic                          port_d_pin2,
  // Array programming
  input  wire logic [pgl_pkg::DEC_PT-1:0][pgl_pkg::IN_W-1:0] dec_true_mask,
  input  wire logic [pgl_pkg::DEC_PT-1:0][pgl_pkg::IN_W-1:0] dec_comp_mask,
  input  wire logic [pgl_pkg::GEN_PT-1:0][pgl_pkg::IN_W-1:0] gen_true_mask,
  input  wire logic [pgl_pkg::GEN_PT-1:0][pgl_pkg::IN_W-1:0] gen_comp_mask,
  input  wire logic [15:0][pgl_pkg::CELL_CFG_W-1:0]          cell_cfg,
  input  wire logic [15:0]                   cell_port_sel,
  // Decode outputs
  output logic [3:0]                         primary_sector_selects,
  output logic [1:0]                         secondary_sector_selects,
  output logic                               sram_select,
  output logic                               register_block_select,
  output logic [1:0]                         periph_selects,
  // General array outputs
  output logic [7:0]                         page_bits,
  output logic [1:0]                         external_chip_selects,
  output logic [7:0]                         out_cells_group_a,
  output logic [7:0]                         out_cells_group_b,
  output logic [7:0]                         port_a_cells,
  output logic [7:0]                         port_b_cells_a,
  output logic [7:0]                         port_b_cells_b,
  output logic [7:0]                         port_c_cells,
  output logic                               pld_standby
);
  // ==========================================================
  // Product term: unused term (no mask bits) reads as zero
  function automatic logic pterm(input logic [pgl_pkg::IN_W-1:0] v,
                                 input logic [pgl_pkg::IN_W-1:0] t,
                                 input logic [pgl_pkg::IN_W-1:0] c);
    pterm = (|(t | c)) & (&(~t | v)) & (&(~c | ~v));
  endfunction

  // ==========================================================
  // Pin synchronisers
  logic [22:0] pin_meta_q;
  logic [22:0] pin_sync_q;
  logic        clk_pin_q;
  logic        pin_rise;

  // Two flops before any logic reads a pin
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      pin_meta_q <= 23'h000000;
      pin_sync_q <= 23'h000000;
    end
    else
    begin
      pin_meta_q <= {cell_clock_pin, port_d_pin2, power_down_input, input_cell_pins};
      pin_sync_q <= pin_meta_q;
    end
  end

  // Edge history of the synchronised clock pin
  always_ff @(posedge core_clk)
  begin
    if (rst)
      clk_pin_q <= 1'b0;
    else
      clk_pin_q <= pin_sync_q[22];
  end

  assign pin_rise = pin_sync_q[22] & ~clk_pin_q;

  // ==========================================================
  // Array input vector
  logic [pgl_pkg::IN_W-1:0] arr_in;
  logic [3:0]               stb_raw;
  logic [3:0]               stb_arr;
  logic                     rst_arr;
  logic [15:0]              feedback;
  logic [7:0]               page_q;

  assign stb_raw = {ale, ~wr_n, ~rd_n, ~program_fetch_strobe_n};
  // Blocked strobes read inactive; only safe if no equation uses them
  assign stb_arr = stb_raw & ~strobe_block[3:0];
  assign rst_arr = rst & ~strobe_block[4];

  // Shared input bus of both arrays
  always_comb
  begin
    arr_in = '0;
    arr_in[pgl_pkg::IX_ADDR +: 16]                  = addr;
    arr_in[pgl_pkg::IX_STB +: 4]                    = stb_arr;
    arr_in[pgl_pkg::IX_RST]                         = rst_arr;
    arr_in[pgl_pkg::IX_PDN]                         = pin_sync_q[20];
    arr_in[pgl_pkg::IX_ICELL +: pgl_pkg::N_ICELL]   = pin_sync_q[19:0];
    arr_in[pgl_pkg::IX_PORTD]                       = pin_sync_q[22];
    arr_in[pgl_pkg::IX_PORTD + 1]                   = pin_sync_q[21];
    arr_in[pgl_pkg::IX_PAGE +: 8]                   = page_q;
    arr_in[pgl_pkg::IX_FB +: pgl_pkg::N_CELL]       = feedback;
    arr_in[pgl_pkg::IX_READY]                       = flash_ready;
  end

  // ==========================================================
  // Decode and general array terms
  logic [pgl_pkg::DEC_PT-1:0] dec_pt;
  logic [pgl_pkg::GEN_PT-1:0] gen_pt;

  genvar gi;
  generate
    for (gi = 0; gi < pgl_pkg::DEC_PT; gi++)
    begin : g_dec
      assign dec_pt[gi] = pterm(arr_in, dec_true_mask[gi], dec_comp_mask[gi]);
    end
    for (gi = 0; gi < pgl_pkg::GEN_PT; gi++)
    begin : g_gen
      assign gen_pt[gi] = pterm(arr_in, gen_true_mask[gi], gen_comp_mask[gi]);
    end
  endgenerate

  // Select sums formed from their term groups
  logic [3:0] pri_sel;
  logic [1:0] sec_sel;
  logic       rbs_sel;
  logic [1:0] ecs_sel;

  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_pri
      assign pri_sel[gi] = |dec_pt[pgl_pkg::DX_PRI + gi*pgl_pkg::PRI_TERMS +: 3];
    end
    for (gi = 0; gi < 2; gi++)
    begin : g_sec
      assign sec_sel[gi] = |dec_pt[pgl_pkg::DX_SEC + gi*pgl_pkg::SEC_TERMS +: 3];
      assign ecs_sel[gi] = |gen_pt[pgl_pkg::GX_ECS + gi*pgl_pkg::ECS_TERMS +: 3];
    end
  endgenerate

  assign rbs_sel = dec_pt[pgl_pkg::DX_RBS];

  // Registered select outputs, one cycle behind the address
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      primary_sector_selects   <= 4'h0;
      secondary_sector_selects <= 2'h0;
      sram_select              <= 1'b0;
      register_block_select    <= 1'b0;
      periph_selects           <= 2'h0;
      external_chip_selects    <= 2'h0;
    end
    else
    begin
      primary_sector_selects   <= pri_sel;
      secondary_sector_selects <= sec_sel;
      sram_select              <= |dec_pt[pgl_pkg::DX_SRAM +: 2];
      register_block_select    <= rbs_sel;
      periph_selects           <= dec_pt[pgl_pkg::DX_PERI +: 2] & {2{periph_io_mode}};
      external_chip_selects    <= ecs_sel;
    end
  end

  // ==========================================================
  // Register access over the internal data bus
  logic       wr_n_q;
  logic       wr_pulse;
  logic       hit_page;
  logic       hit_ca;
  logic       hit_cb;
  logic [7:0] cells_a_q;
  logic [7:0] cells_b_q;

  // Write acts once, on the falling edge of the write strobe
  always_ff @(posedge core_clk)
  begin
    if (rst)
      wr_n_q <= 1'b1;
    else
      wr_n_q <= wr_n;
  end

  assign wr_pulse = wr_n_q & ~wr_n;
  assign hit_page = rbs_sel & (addr[7:0] == pgl_pkg::OFS_PAGE);
  assign hit_ca   = rbs_sel & (addr[7:0] == pgl_pkg::OFS_CELLS_A);
  assign hit_cb   = rbs_sel & (addr[7:0] == pgl_pkg::OFS_CELLS_B);

  // Page register, bit i on data line i
  always_ff @(posedge core_clk)
  begin
    if (rst)
      page_q <= pgl_pkg::PAGE_RESET;
    else if (wr_pulse & hit_page)
      page_q <= data_in;
  end

  assign page_bits = page_q;

  // Read data mux, registered while the read strobe is low
  always_ff @(posedge core_clk)
  begin
    if (rst)
      data_out <= pgl_pkg::RDATA_UNMAP;
    else if (~rd_n & rbs_sel)
    begin
      case (addr[7:0])
        pgl_pkg::OFS_PAGE:     data_out <= page_q;
        pgl_pkg::OFS_CELLS_A:  data_out <= cells_a_q;
        pgl_pkg::OFS_CELLS_B:  data_out <= cells_b_q;
        pgl_pkg::OFS_INCELL_A: data_out <= pin_sync_q[7:0];
        pgl_pkg::OFS_INCELL_B: data_out <= pin_sync_q[15:8];
        pgl_pkg::OFS_INCELL_C: data_out <= {4'h0, pin_sync_q[19:16]};
        default:               data_out <= pgl_pkg::RDATA_UNMAP;
      endcase
    end
  end

  // Drive the bus only during a selected read
  assign data_out_en = ~rd_n & register_block_select;

  // ==========================================================
  // Output cells
  logic [15:0] cell_q;

  generate
    for (gi = 0; gi < pgl_pkg::N_CELL; gi++)
    begin : g_cell
      pgl_out_cell u_cell (
        .core_clk    (core_clk),
        .rst         (rst),
        .sum_terms   (gen_pt[gi*pgl_pkg::CELL_PT +: 4]),
        .preset_term (gen_pt[gi*pgl_pkg::CELL_PT + 4]),
        .clear_terms (gen_pt[gi*pgl_pkg::CELL_PT + 5 +: 2]),
        .clk_term    (gen_pt[gi*pgl_pkg::CELL_PT + 7]),
        .polarity    (cell_cfg[gi][0]),
        .ff_kind     (cell_cfg[gi][2:1]),
        .registered  (cell_cfg[gi][3]),
        .use_pin_clk (cell_cfg[gi][4]),
        .pin_rise    (pin_rise),
        .load        (wr_pulse & ((gi < 8) ? hit_ca : hit_cb)),
        .load_bit    (data_in[gi % 8]),
        .cell_out    (feedback[gi]),
        .cell_q      (cell_q[gi])
      );
    end
  endgenerate

  assign cells_a_q = cell_q[7:0];
  assign cells_b_q = cell_q[15:8];

  // Cell results to their ports; group A on A or B, group B on B or C
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      out_cells_group_a <= 8'h00;
      out_cells_group_b <= 8'h00;
      port_a_cells      <= 8'h00;
      port_b_cells_a    <= 8'h00;
      port_b_cells_b    <= 8'h00;
      port_c_cells      <= 8'h00;
    end
    else
    begin
      out_cells_group_a <= feedback[7:0];
      out_cells_group_b <= feedback[15:8];
      port_a_cells      <= feedback[7:0] & ~cell_port_sel[7:0];
      port_b_cells_a    <= feedback[7:0] & cell_port_sel[7:0];
      port_b_cells_b    <= feedback[15:8] & ~cell_port_sel[15:8];
      port_c_cells      <= feedback[15:8] & cell_port_sel[15:8];
    end
  end

  // ==========================================================
  // Standby detect: idle inputs for the standby time, fast mode off
  logic [pgl_pkg::IN_W-1:0]        arr_in_q;
  logic [pgl_pkg::STBY_CNT_W-1:0]  idle_q;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      arr_in_q <= '0;
      idle_q   <= '0;
    end
    else
    begin
      arr_in_q <= arr_in;
      if (fast_mode | (arr_in != arr_in_q))
        idle_q <= '0;
      else if (idle_q != pgl_pkg::STBY_CYC[pgl_pkg::STBY_CNT_W-1:0])
        idle_q <= idle_q + 1'b1;
    end
  end

  // Standby only flags power state; logic results stay valid
  assign pld_standby = ~fast_mode &
                       (idle_q == pgl_pkg::STBY_CYC[pgl_pkg::STBY_CNT_W-1:0]);
endmodule

// ===== dv/pgl_mcu_model.sv
// Processor core model on the module register bus
`timescale 1ns/1ns
module pgl_mcu_model (
  // Clock
  input  wire logic       core_clk,
  // Strobes and address
  output logic [15:0]     addr,
  output logic            program_fetch_strobe_n,
  output logic            rd_n,
  output logic            wr_n,
  output logic            ale,
  // Data lines
  output logic [7:0]      data_in,
  input  wire logic [7:0] data_out
);
  // ==========
  // Quiet bus from time zero
  initial
  begin
    addr = 16'h0000;
    program_fetch_strobe_n = 1'b1;
    {rd_n, wr_n, ale} = 3'b110;
    data_in = 8'h00;
  end

  // Write: address settles a cycle before the strobe falls
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge core_clk);
    addr = a;
    data_in = d;
    @(negedge core_clk);
    wr_n = 1'b0;
    @(negedge core_clk);
    wr_n = 1'b1;
    data_in = ~d;  // Released lines show junk, not the old value
  endtask

  // Read: strobe held over two edges, data taken before release
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(negedge core_clk);
    addr = a;
    @(negedge core_clk);
    rd_n = 1'b0;
    repeat (2) @(negedge core_clk);
    d = data_out;
    rd_n = 1'b1;
  endtask

  // Address latch strobe level
  task automatic set_ale(input logic v);
    @(negedge core_clk);
    ale = v;
  endtask
endmodule

// ===== dv/pgl_fabric_chk.sv
// Port assertions for the paging register and logic fabric
`timescale 1ns/1ns
module pgl_fabric_chk (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        rst,
  // Processor bus
  input wire logic [15:0] addr,
  input wire logic        rd_n,
  input wire logic        wr_n,
  input wire logic [7:0]  data_in,
  input wire logic [7:0]  data_out,
  input wire logic        data_out_en,
  // Status and results
  input wire logic        periph_io_mode,
  input wire logic        fast_mode,
  input wire logic [7:0]  page_bits,
  input wire logic        register_block_select,
  input wire logic [1:0]  periph_selects,
  input wire logic        pld_standby
);
  // ==========
  // One clock; reset masks all but the reset check
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  // ==========
  // Paging register and read path
  a_page_write:
    assert property ($fell(wr_n) && register_block_select && $stable(addr) &&
      addr[7:0] == 8'he0 |=> page_bits == $past(data_in)) else $error("page write lost");
  a_page_hold:
    assert property (!$fell(wr_n) |=> $stable(page_bits)) else $error("page changed");
  a_page_reset:
    assert property (disable iff (1'b0) rst |=> page_bits == 8'h00)
      else $error("page not cleared");
  a_read_back:
    assert property (!rd_n && register_block_select && $stable(addr) && addr[7:0] == 8'he0
      && $stable(page_bits) |=> data_out == $past(page_bits)) else $error("page readback");
  a_unmap_read:
    assert property (!rd_n && register_block_select && $stable(addr) &&
      !(addr[7:0] inside {8'he0, 8'h20, 8'h21, 8'h10, 8'h11, 8'h12})
      |=> data_out == 8'h00) else $error("unmapped read not zero");
  a_rd_enable:
    assert property (data_out_en == (!rd_n && register_block_select))
      else $error("read enable wrong");

  // ==========
  // Mode gating and standby; counter may lag one edge
  a_periph_gate:
    assert property (!$past(periph_io_mode) |-> periph_selects == 2'b00)
      else $error("periph select without mode");
  a_fast_awake:
    assert property (fast_mode && $past(fast_mode) |-> !pld_standby)
      else $error("standby in fast mode");
  a_wake_change:
    assert property ($changed(addr) |-> ##2 !pld_standby) else $error("standby while busy");
endmodule

bind pgl_fabric pgl_fabric_chk u_chk (
  .core_clk, .rst, .addr, .rd_n, .wr_n, .data_in, .data_out, .data_out_en,
  .periph_io_mode, .fast_mode, .page_bits, .register_block_select,
  .periph_selects, .pld_standby
);

// ===== dv/tb_top.sv
// Self-checking testbench for the paging register and logic fabric
`timescale 1ns/1ns
module tb_top;
  // ==========
  // Design signals
  logic        core_clk, rst, program_fetch_strobe_n, rd_n, wr_n, ale, data_out_en;
  logic        periph_io_mode, fast_mode, cell_clock_pin, sram_select;
  logic        register_block_select, pld_standby;
  logic        flash_ready, power_down_input, port_d_pin2;
  logic [15:0] cell_port_sel;
  logic [7:0]  port_b_cells_a;
  logic [15:0] addr;
  logic [7:0]  data_in, data_out, page_bits, out_cells_group_a, port_a_cells, rv;
  logic [4:0]  strobe_block;
  logic [19:0] input_cell_pins;
  logic [3:0]  primary_sector_selects;
  logic [1:0]  secondary_sector_selects, periph_selects, external_chip_selects;
  logic [pgl_pkg::DEC_PT-1:0][pgl_pkg::IN_W-1:0] dtm, dcm;
  logic [pgl_pkg::GEN_PT-1:0][pgl_pkg::IN_W-1:0] gtm, gcm;
  logic [15:0][pgl_pkg::CELL_CFG_W-1:0]          cell_cfg;
  int          fails, n_checks;
  localparam int IC = pgl_pkg::IX_ICELL;

  // ==========
  // Design and processor model
  pgl_fabric dut (
    .core_clk, .rst, .addr, .program_fetch_strobe_n, .rd_n, .wr_n, .ale, .data_in,
    .data_out, .data_out_en, .flash_ready, .periph_io_mode, .fast_mode,
    .strobe_block, .power_down_input, .input_cell_pins, .cell_clock_pin,
    .port_d_pin2, .dec_true_mask (dtm), .dec_comp_mask (dcm),
    .gen_true_mask (gtm), .gen_comp_mask (gcm), .cell_cfg, .cell_port_sel,
    .primary_sector_selects, .secondary_sector_selects, .sram_select,
    .register_block_select, .periph_selects, .page_bits, .external_chip_selects,
    .out_cells_group_a, .out_cells_group_b (), .port_a_cells, .port_b_cells_a,
    .port_b_cells_b (), .port_c_cells (), .pld_standby
  );
  pgl_mcu_model mcu (
    .core_clk, .addr, .program_fetch_strobe_n, .rd_n, .wr_n, .ale, .data_in, .data_out
  );

  // Free-running core clock
  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // ==========
  // Shared helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ==========
  // Scenarios
  task automatic t_page();
    logic [7:0] pat [5] = '{8'h01, 8'h80, 8'ha5, 8'h5a, 8'hff};
    chk(page_bits, 8'h00, "page at reset");
    foreach (pat[i])
    begin
      mcu.wr(16'h80e0, pat[i]);
      chk(page_bits, pat[i], "page write");
      mcu.rd(16'h80e0, rv);
      chk(rv, pat[i], "page read");
    end
    mcu.wr(16'h80e0, 8'h3c);
    mcu.wr(16'h80e0, 8'hc3);
    mcu.wr(16'h80e1, 8'h33);
    mcu.wr(16'h00e0, 8'h44);
    chk(page_bits, 8'hc3, "back to back, ignored writes");
    mcu.rd(16'h80e1, rv);
    chk(rv, 8'h00, "unmapped read");
    // Second reset in mid-run must clear a written page
    mcu.wr(16'h80e0, 8'h96);
    rst = 1'b1;
    idle(2);
    rst = 1'b0;
    chk(page_bits, 8'h00, "page after mid-run reset");
  endtask
  // Page bits drive decode and chip selects
  task automatic t_decode();
    mcu.wr(16'h80e0, 8'h07);
    mcu.wr(16'h4000, 8'h00);
    idle(2);
    chk({primary_sector_selects, sram_select, external_chip_selects,
         register_block_select}, 8'h1a, "paged selects");
    chk(8'(secondary_sector_selects), 8'h01, "second flash");
    mcu.wr(16'h80e0, 8'h00);
    idle(2);
    chk({primary_sector_selects, sram_select, external_chip_selects,
         register_block_select}, 8'h01, "page zero");
    // Ready, power-down and port D pin each raise one primary select
    {flash_ready, power_down_input, port_d_pin2} = 3'b111;
    idle(4);
    chk(8'(primary_sector_selects), 8'h0e, "ready, power-down, port D");
    {flash_ready, power_down_input, port_d_pin2} = 3'b000;
    chk(8'(periph_selects), 8'h00, "periph off");
    periph_io_mode = 1'b1;
    idle(2);
    chk(8'(periph_selects), 8'h01, "periph on");
    periph_io_mode = 1'b0;
    mcu.set_ale(1'b1);
    idle(2);
    chk(8'(secondary_sector_selects), 8'h02, "strobe seen");
    strobe_block = 5'h08;
    idle(2);
    chk(8'(secondary_sector_selects), 8'h00, "strobe blocked");
    strobe_block = 5'h00;
  endtask
  // Cells: one kind each, loaded then ticked by the clock pin
  task automatic t_cells();
    idle(8);
    chk(8'({out_cells_group_a[0], port_a_cells[0]}), 8'h03, "comb cell");
    cell_port_sel = 16'h0001;
    idle(2);
    chk(8'({port_a_cells[0], port_b_cells_a[0]}), 8'h01, "second port");
    cell_port_sel = 16'h0000;
    mcu.rd(16'h8010, rv);
    chk(rv, 8'h04, "input cells");
    mcu.wr(16'h8020, 8'h02);
    idle(3);
    chk(8'(out_cells_group_a[4:1]), 8'h01, "cell load");
    mcu.rd(16'h8020, rv);
    chk(8'(rv[4:1]), 8'h01, "cell read");
    mcu.wr(16'h8021, 8'ha5);
    mcu.rd(16'h8021, rv);
    chk(rv, 8'ha5, "cells B read");
    cell_clock_pin = 1'b1;
    idle(6);
    chk(8'(out_cells_group_a[4:1]), 8'h06, "first tick");
    cell_clock_pin = 1'b0;
    input_cell_pins = 20'h00006;
    idle(6);
    chk(8'(out_cells_group_a[4:1]), 8'h06, "falling edge");
    cell_clock_pin = 1'b1;
    idle(6);
    chk(8'(out_cells_group_a[4:1]), 8'h09, "second tick");
    // Input cell 3 presets cell 5 and clocks cell 6; input cell 4 clears cell 5
    input_cell_pins = 20'h0000e;
    idle(6);
    chk(8'(out_cells_group_a[6:5]), 8'h03, "preset, term clock");
    input_cell_pins = 20'h00016;
    idle(6);
    chk(8'(out_cells_group_a[6:5]), 8'h02, "clear, no fall tick");
  endtask
  task automatic t_standby();
    fast_mode = 1'b0;
    mcu.wr(16'h0000, 8'h00);
    idle(2);
    chk(8'(pld_standby), 8'h00, "still busy");
    idle(5);
    chk(8'(pld_standby), 8'h01, "standby");
    fast_mode = 1'b1;
    idle(2);
    chk(8'(pld_standby), 8'h00, "fast mode");
  endtask

  // ==========
  // Programming, reset and main sequence
  initial
  begin
    {dtm, dcm, gtm, gcm, cell_cfg} = '0;
    {rst, periph_io_mode, fast_mode, cell_clock_pin} = 4'b1010;
    strobe_block = 5'h00;
    input_cell_pins = 20'h00004;
    {flash_ready, power_down_input, port_d_pin2} = 3'b000;
    cell_port_sel = 16'h0000;
    fails = 0;
    n_checks = 0;
    dtm[20][15] = 1'b1;                   // Register block and periph on A15
    dtm[21][15] = 1'b1;
    dtm[0][pgl_pkg::IX_PAGE] = 1'b1;      // Paged selects on page bits 0..2
    dtm[18][pgl_pkg::IX_PAGE+1] = 1'b1;
    gtm[128][pgl_pkg::IX_PAGE+2] = 1'b1;
    dtm[12][14] = 1'b1;                   // Second flash 0 on A14, 1 on latch strobe
    dtm[15][pgl_pkg::IX_STB+3] = 1'b1;
    dtm[3][pgl_pkg::IX_READY] = 1'b1;     // Primary 1..3 on ready, power-down, port D
    dtm[6][pgl_pkg::IX_PDN] = 1'b1;
    dtm[9][pgl_pkg::IX_PORTD+1] = 1'b1;
    gtm[0][IC] = 1'b1;                    // Cell terms: D, T, J/K, S/R
    gtm[8][IC+1] = 1'b1;
    gtm[16][IC+2] = 1'b1;
    gtm[24][IC+2] = 1'b1;
    gtm[26][IC+1] = 1'b1;
    gtm[32][IC+1] = 1'b1;
    gcm[34][IC+1] = 1'b1;
    gtm[44][IC+3] = 1'b1;                 // Cell 5 preset and clear, cell 6 term clock
    gtm[45][IC+4] = 1'b1;
    gtm[48][IC+2] = 1'b1;
    gtm[55][IC+3] = 1'b1;
    cell_cfg[6:0] = {5'h08, 5'h18, 5'h1e, 5'h1c, 5'h1a, 5'h18, 5'h01};
    idle(2);
    rst = 1'b0;
    t_page();
    t_decode();
    t_cells();
    t_standby();
    complete_run();
  end
endmodule
